// ===== irq_pkg.sv
// Purpose: constants and types of the vectored interrupt unit
// Assumes: one clock pclk at 20 MHz, asynchronous active-low reset
// Notes: register map reached over APB, one aligned word each
//
// How it works
// [RQ1] Pin irq needs global and pin enable
// [RQ2] Pin falling edge sets pin flag
// [RQ3] No interrupt taken while stack full
// [RQ4] Pin interrupt calls vector 04H
// [RQ5] Service clears source flag and global enable
// [RQ6] Timer irqs need global plus own enable
// [RQ7] Timer overflow sets its request flag
// [RQ8] Timer vectors 08H and 0CH
// [RQ9] Tone valid sets periph flag; needs enables
// [RQ10] Periph interrupt calls vector 10H
// [RQ11] Clock timeout sets flag; needs enables
// [RQ12] Clock interrupt calls vector 14H
// [RQ13] Port edges, serial, ext, timer3 set multi
// [RQ14] Multi irq needs global and multi enable
// [RQ15] Multi interrupt calls vector 18H
// [RQ16] Flag stays until serviced or software-cleared
// [RQ17] Any pending source wakes from power-down
// [RQ18] Only program counter pushed on entry
// [RQ19] Priority pin, timers, periph, clock, multi
// [RQ20] Requests acted on at phase-two edge
// [RQ21] Each edge registered once per clock
// [RQ22] Vector, call, clears in one cycle
`default_nettype none
package irq_pkg;
	localparam int NSRC = 6;
	// Source index, also priority order (0 highest)
	localparam int SRC_PIN = 0;
	localparam int SRC_TMA = 1;
	localparam int SRC_TMB = 2;
	localparam int SRC_PER = 3;
	localparam int SRC_CLK = 4;
	localparam int SRC_MUL = 5;
	localparam logic [7:0] VEC_PIN = 8'h04;
	localparam logic [7:0] VEC_TMA = 8'h08;
	localparam logic [7:0] VEC_TMB = 8'h0C;
	localparam logic [7:0] VEC_PER = 8'h10;
	localparam logic [7:0] VEC_CLK = 8'h14;
	localparam logic [7:0] VEC_MUL = 8'h18;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_FLAG = 12'h004;
	localparam logic [11:0] OFF_STAT = 12'h008;
	// Control register field positions
	localparam int CTRL_GLOBAL = 0;
	localparam int CTRL_EN_LSB = 1;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam logic [5:0] FLAG_RST = 6'h00;
	typedef struct packed {
		logic pin_n;
		logic tmr_a_ovf;
		logic tmr_b_ovf;
		logic tone_valid;
		logic rtc_tick;
		logic portc_bit_zero;
		logic portc_bit_five;
		logic portc_bit_seven;
		logic serial_evt;
		logic ext_periph_n;
		logic tmr_c_ovf;
	} irq_src_t;
	typedef struct packed {
		logic call;
		logic [7:0] vector;
	} irq_call_t;
endpackage
`default_nettype wire

// ===== vectored_interrupt_unit.sv
// Purpose: vectored interrupt unit with APB register access
// Assumes: sources synchronous to pclk; core gives stack_full and phase-two strobe
// Notes: call is a one-cycle pulse with its vector; core pushes only the PC
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_unit
	import irq_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request sources
	input wire irq_src_t src,
	// Core side
	input wire logic stack_full,
	input wire logic machine_phase_two,
	output irq_call_t call_q,
	output logic wake_q
);
	// ****************************************
	// Edge detection and flags
	// ****************************************
	irq_src_t src_q;
	logic [NSRC-1:0] set_ev;
	logic [NSRC-1:0] flag_q;
	logic [NSRC-1:0] en_q;
	logic global_irq_enable;
	logic [NSRC-1:0] take;
	logic [NSRC-1:0] pend;
	logic wr_acc;
	logic rd_acc;
	logic any_take;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= '0;
		end else begin
			src_q <= src; // see [RQ21]
		end
	end

	always_comb begin
		set_ev[SRC_PIN] = src_q.pin_n & ~src.pin_n; // see [RQ2]
		set_ev[SRC_TMA] = src.tmr_a_ovf & ~src_q.tmr_a_ovf; // see [RQ7]
		set_ev[SRC_TMB] = src.tmr_b_ovf & ~src_q.tmr_b_ovf; // see [RQ7]
		set_ev[SRC_PER] = src.tone_valid & ~src_q.tone_valid; // see [RQ9]
		set_ev[SRC_CLK] = src.rtc_tick & ~src_q.rtc_tick; // see [RQ11]
		set_ev[SRC_MUL] = (src_q.portc_bit_zero & ~src.portc_bit_zero)
			| (src_q.portc_bit_five & ~src.portc_bit_five)
			| (src.portc_bit_seven & ~src_q.portc_bit_seven)
			| (src.serial_evt & ~src_q.serial_evt)
			| (src_q.ext_periph_n & ~src.ext_periph_n)
			| (src.tmr_c_ovf & ~src_q.tmr_c_ovf); // see [RQ13]
	end

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;

	// Set wins over both service clear and software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= FLAG_RST;
		end else begin
			flag_q <= set_ev | (flag_q & ~take
				& ~((wr_acc && paddr == OFF_FLAG) ? ~pwdata[NSRC-1:0] : '0)); // see [RQ16] [RQ5]
		end
	end

	// ****************************************
	// Selection and call
	// ****************************************
	assign pend = flag_q & en_q & {NSRC{global_irq_enable}}; // see [RQ1] [RQ6] [RQ9] [RQ11] [RQ14]

	// Lowest index wins
	always_comb begin
		take = '0;
		if (machine_phase_two && !stack_full) begin // see [RQ3] [RQ20]
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (pend[i]) begin
					take = '0;
					take[i] = 1'b1; // see [RQ19]
				end
			end
		end
	end
	assign any_take = |take;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			call_q <= '0;
		end else begin
			call_q.call <= any_take; // see [RQ22] [RQ18]
			case (1'b1)
				take[SRC_PIN]: call_q.vector <= VEC_PIN; // see [RQ4]
				take[SRC_TMA]: call_q.vector <= VEC_TMA; // see [RQ8]
				take[SRC_TMB]: call_q.vector <= VEC_TMB; // see [RQ8]
				take[SRC_PER]: call_q.vector <= VEC_PER; // see [RQ10]
				take[SRC_CLK]: call_q.vector <= VEC_CLK; // see [RQ12]
				take[SRC_MUL]: call_q.vector <= VEC_MUL; // see [RQ15]
				default: call_q.vector <= call_q.vector;
			endcase
		end
	end

	// Wake regardless of enables: a pending flag alone rouses the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= |(flag_q | set_ev); // see [RQ17]
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_enable <= CTRL_RST[CTRL_GLOBAL];
			en_q <= CTRL_RST[CTRL_EN_LSB +: NSRC];
		end else begin
			if (wr_acc && paddr == OFF_CTRL) begin
				en_q <= pwdata[CTRL_EN_LSB +: NSRC];
			end
			if (any_take) begin
				global_irq_enable <= 1'b0; // see [RQ5] [RQ22]
			end else if (wr_acc && paddr == OFF_CTRL) begin
				global_irq_enable <= pwdata[CTRL_GLOBAL];
			end
		end
	end

	// ****************************************
	// APB read path, zero wait states
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & paddr != OFF_CTRL & paddr != OFF_FLAG & paddr != OFF_STAT;
			prdata <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					OFF_CTRL: prdata <= {25'h0, en_q, global_irq_enable};
					OFF_FLAG: prdata <= {26'h0, flag_q};
					OFF_STAT: prdata <= {26'h0, pend};
					default: prdata <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Named sequences for the call steps
	// Strobe high, room on the stack and an armed request
	sequence s_slot_ready;
		machine_phase_two && !stack_full && (|pend);
	endsequence
	// The call leaves with the global gate already shut
	sequence s_called;
		call_q.call && !global_irq_enable;
	endsequence
	sequence s_called_pin;
		call_q.call && call_q.vector == VEC_PIN;
	endsequence
	sequence s_called_tma;
		call_q.call && call_q.vector == VEC_TMA;
	endsequence
	sequence s_called_tmb;
		call_q.call && call_q.vector == VEC_TMB;
	endsequence
	sequence s_called_per;
		call_q.call && call_q.vector == VEC_PER;
	endsequence
	sequence s_called_clk;
		call_q.call && call_q.vector == VEC_CLK;
	endsequence
	// Falling pin edge, then the flag one clock later
	sequence s_pin_raise;
		set_ev[SRC_PIN] ##1 flag_q[SRC_PIN];
	endsequence

	// ****************************************
	// Gating checks
	// ****************************************
	AST_NO_TAKE_FULL: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ3]
		stack_full |=> !call_q.call)
		else $error("call while stack full");
	AST_NEED_GIE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ1]
		!global_irq_enable |=> !call_q.call)
		else $error("call without global enable");
	AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ20]
		!machine_phase_two |=> !call_q.call)
		else $error("call off phase two");
	AST_TAKE_GATED: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ3] [RQ20]
		any_take |-> machine_phase_two && !stack_full)
		else $error("take outside a free slot");
	AST_TAKE_PENDING: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ6]
		(take & ~pend) == '0)
		else $error("take of a source not pending");
	AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ1]
		take[SRC_PIN] |-> en_q[SRC_PIN] && global_irq_enable)
		else $error("pin taken while masked");
	AST_TMA_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ6]
		take[SRC_TMA] |-> en_q[SRC_TMA] && global_irq_enable)
		else $error("timer a taken while masked");
	AST_TMB_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ6]
		take[SRC_TMB] |-> en_q[SRC_TMB] && global_irq_enable)
		else $error("timer b taken while masked");
	AST_PER_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ9]
		take[SRC_PER] |-> en_q[SRC_PER] && global_irq_enable)
		else $error("periph taken while masked");
	AST_CLK_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ11]
		take[SRC_CLK] |-> en_q[SRC_CLK] && global_irq_enable)
		else $error("clock taken while masked");
	AST_MUL_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ14]
		take[SRC_MUL] |-> en_q[SRC_MUL] && global_irq_enable)
		else $error("multi taken while masked");

	// ****************************************
	// Priority checks
	// ****************************************
	AST_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		(any_take && pend[SRC_PIN]) |-> take[SRC_PIN])
		else $error("priority wrong");
	AST_ONE_TAKE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		$onehot0(take))
		else $error("more than one source taken");
	AST_TMA_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		any_take && pend[SRC_TMA] && !pend[SRC_PIN] |-> take[SRC_TMA])
		else $error("timer a passed over");
	AST_TMB_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		any_take && pend[SRC_TMB] && pend[SRC_TMA:SRC_PIN] == '0 |-> take[SRC_TMB])
		else $error("timer b passed over");
	AST_PER_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		any_take && pend[SRC_PER] && pend[SRC_TMB:SRC_PIN] == '0 |-> take[SRC_PER])
		else $error("periph passed over");
	AST_CLK_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		any_take && pend[SRC_CLK] && pend[SRC_PER:SRC_PIN] == '0 |-> take[SRC_CLK])
		else $error("clock passed over");
	AST_MUL_LAST: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ19]
		take[SRC_MUL] |-> pend[SRC_CLK:SRC_PIN] == '0)
		else $error("multi taken ahead of others");
	AST_PIN_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ4]
		machine_phase_two && !stack_full && pend[SRC_PIN] |=> s_called_pin)
		else $error("pending pin not called first");

	// ****************************************
	// Call checks
	// ****************************************
	AST_SLOT_CALLS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ22]
		s_slot_ready |=> s_called)
		else $error("free slot without call");
	AST_GIE_CLEARED: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ5]
		any_take |=> !global_irq_enable)
		else $error("global enable not cleared");
	AST_CALL_FROM_TAKE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ22]
		call_q.call |-> $past(any_take))
		else $error("call without a take");
	AST_CALL_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ22]
		call_q.call |=> !call_q.call)
		else $error("call longer than one cycle");
	AST_VEC_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ22]
		!any_take |=> $stable(call_q.vector))
		else $error("vector moved without a call");
	AST_PIN_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ4]
		take[SRC_PIN] |=> call_q.call && call_q.vector == VEC_PIN)
		else $error("pin vector wrong");
	AST_TMA_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ8]
		take[SRC_TMA] |=> s_called_tma)
		else $error("timer a vector wrong");
	AST_TMB_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ8]
		take[SRC_TMB] |=> s_called_tmb)
		else $error("timer b vector wrong");
	AST_PER_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ10]
		take[SRC_PER] |=> s_called_per)
		else $error("periph vector wrong");
	AST_CLK_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ12]
		take[SRC_CLK] |=> s_called_clk)
		else $error("clock vector wrong");
	AST_MUL_VEC: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ15]
		take[SRC_MUL] |=> call_q.vector == VEC_MUL)
		else $error("multi vector wrong");
	AST_GIE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ5]
		wr_acc && paddr == OFF_CTRL && !any_take |=> global_irq_enable == $past(pwdata[CTRL_GLOBAL]))
		else $error("global enable write lost");

	// ****************************************
	// Flag checks
	// ****************************************
	AST_PIN_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ2]
		($fell(src.pin_n) && !take[SRC_PIN]) |=> flag_q[SRC_PIN])
		else $error("pin flag not set");
	AST_PIN_RAISE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ2]
		$fell(src.pin_n) && src_q.pin_n |-> s_pin_raise)
		else $error("pin edge not raised");
	AST_TMA_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ7]
		$rose(src.tmr_a_ovf) |=> flag_q[SRC_TMA])
		else $error("timer a flag not set");
	AST_TMB_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ7]
		$rose(src.tmr_b_ovf) |=> flag_q[SRC_TMB])
		else $error("timer b flag not set");
	AST_TONE_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ9]
		$rose(src.tone_valid) |=> flag_q[SRC_PER])
		else $error("periph flag not set");
	AST_RTC_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ11]
		$rose(src.rtc_tick) |=> flag_q[SRC_CLK])
		else $error("clock flag not set");
	AST_PC7_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$rose(src.portc_bit_seven) |=> flag_q[SRC_MUL])
		else $error("multi flag missed port rise");
	AST_SER_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$rose(src.serial_evt) |=> flag_q[SRC_MUL])
		else $error("multi flag missed serial event");
	AST_TMC_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$rose(src.tmr_c_ovf) |=> flag_q[SRC_MUL])
		else $error("multi flag missed timer c");
	AST_PC0_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$fell(src.portc_bit_zero) && src_q.portc_bit_zero |=> flag_q[SRC_MUL])
		else $error("multi flag missed port bit zero");
	AST_PC5_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$fell(src.portc_bit_five) && src_q.portc_bit_five |=> flag_q[SRC_MUL])
		else $error("multi flag missed port bit five");
	AST_EXT_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ13]
		$fell(src.ext_periph_n) && src_q.ext_periph_n |=> flag_q[SRC_MUL])
		else $error("multi flag missed external edge");
	AST_READ_KEEPS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ16]
		rd_acc && !(|set_ev) && !any_take |=> flag_q == $past(flag_q))
		else $error("read disturbed the flags");
	// Per flag: set wins, clears act, nothing appears by itself
	for (genvar g = 0; g < NSRC; g++) begin : g_flag_chk
		AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ21]
			set_ev[g] |=> flag_q[g])
			else $error("flag lost its set");
		AST_SVC_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ5]
			take[g] && !set_ev[g] |=> !flag_q[g])
			else $error("service left flag set");
		AST_FLAG_STAYS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ16]
			flag_q[g] && !take[g] && !(wr_acc && paddr == OFF_FLAG && !pwdata[g]) |=> flag_q[g])
			else $error("flag dropped by itself");
		AST_SW_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ16]
			wr_acc && paddr == OFF_FLAG && !pwdata[g] && !set_ev[g] |=> !flag_q[g])
			else $error("software clear ignored");
		AST_NO_FLAG_ALONE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ21]
			!flag_q[g] && !set_ev[g] |=> !flag_q[g])
			else $error("flag rose without an edge");
	end

	// ****************************************
	// Wake checks
	// ****************************************
	AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ17]
		(|flag_q) |=> wake_q)
		else $error("no wake");
	AST_WAKE_EVENT: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ17]
		(|set_ev) |=> wake_q)
		else $error("no wake on edge");
	AST_WAKE_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ17]
		!(|flag_q) && !(|set_ev) |=> !wake_q)
		else $error("wake with nothing pending");
	AST_WAKE_UNMASKED: assert property (@(posedge pclk) disable iff (!presetn) // see [RQ17]
		(|flag_q) && !global_irq_enable |=> wake_q)
		else $error("wake blocked by global gate");
endmodule
`default_nettype wire

// ===== core_model.sv
// Purpose: behavioural core: return stack depth and phase-two strobe
// Assumes: one push per call, one pop per return pulse
// Notes: only the return address is stacked
`timescale 1ns/1ps
`default_nettype none
module core_model #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Unit side
	input wire logic call,
	input wire logic pop,
	output logic machine_phase_two,
	output logic stack_full
);
	int depth_q;
	logic [1:0] phase_q;
	// Push holds the program counter alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			depth_q <= 0;
		end else begin
			depth_q <= depth_q + int'(call) - int'(pop && depth_q > 0);
		end
	end
	// Strobe every fourth cycle, so requests wait for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	assign machine_phase_two = (phase_q == 2'h3);
	assign stack_full = (depth_q >= DEPTH);
endmodule
`default_nettype wire

// ===== vectored_interrupt_unit_tb_top.sv
// Purpose: self-checking bench of the vectored interrupt unit
// Assumes: core model answers calls, stack two deep
// Notes: a source fires by toggling its bit for one cycle
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_unit_tb_top
	import irq_pkg::*;
;
	// Falling-edge inputs idle high
	localparam logic [10:0] IDLE = 11'h432;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic stack_full, mp2, wake_q, pop, hit, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] v;
	irq_src_t src;
	irq_call_t call_q;
	int miscompares = 0;
	int checks = 0;
	vectored_interrupt_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src(src), .stack_full(stack_full), .machine_phase_two(mp2),
		.call_q(call_q), .wake_q(wake_q));
	core_model #(.DEPTH(2)) u_core (.pclk(pclk), .presetn(presetn), .call(call_q.call), .pop(pop),
		.machine_phase_two(mp2), .stack_full(stack_full));
	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [10:0] m);
		@(posedge pclk);
		src <= IDLE ^ m;
		@(posedge pclk);
		src <= IDLE;
	endtask
	task automatic ret();
		@(posedge pclk);
		pop <= 1'b1;
		@(posedge pclk);
		pop <= 1'b0;
	endtask
	task automatic wait_call(input int n);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			@(posedge pclk);
			if (call_q.call === 1'b1) begin
				hit = 1'b1;
				v = call_q.vector;
			end
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#250000;
		miscompares++;
		wrap_up();
	end
	initial begin
		int k;
		{presetn, psel, penable, pwrite, pop} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		src = IDLE;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h0FC, 32'h0);
		chk(er, 1'b1);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk(rd, 32'h0);
		// Each source bit with global and its own enable only
		for (int b = 10; b >= 0; b--) begin
			k = (b > 5) ? 10 - b : 5;
			apb(1'b1, OFF_CTRL, 32'h1 | (32'h2 << k));
			pulse(11'h001 << b);
			wait_call(20);
			chk(hit, 1'b1);
			chk(v, 8'h04 + 8'h04 * k);
			apb(1'b0, OFF_FLAG, 32'h0);
			chk(rd, 32'h0);
			apb(1'b0, OFF_CTRL, 32'h0);
			chk(rd, 32'h2 << k);
			ret();
		end
		// All at once, global off
		pulse(11'h7FF);
		apb(1'b1, OFF_CTRL, 32'h7E);
		wait_call(12);
		chk(hit, 1'b0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk(rd, 32'h3F);
		chk(wake_q, 1'b1);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFF_CTRL, 32'h7F);
			wait_call(20);
			chk(hit, 1'b1);
			chk(v, 8'h04 + 8'h04 * i);
			if (i == 0) ret();
		end
		// Stack now full: request must wait for a pop
		apb(1'b1, OFF_CTRL, 32'h7F);
		wait_call(16);
		chk(hit, 1'b0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd, 32'h38);
		ret();
		wait_call(20);
		chk(v, VEC_PER);
		apb(1'b1, OFF_FLAG, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk(rd, 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
